/* File: design/vafe_pkg.sv */
/*
 * Constants for the video front-end control block: register offsets,
 * field positions, reset values and black-level loop figures.
 * Assumes a byte-wide register port with one-cycle read latency.
 */
package vafe_pkg;
	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] VAFE_OFS_OFFSET_R   = 8'h03;
	localparam logic [7:0] VAFE_OFS_OFFSET_G   = 8'h04;
	localparam logic [7:0] VAFE_OFS_OFFSET_B   = 8'h09;
	localparam logic [7:0] VAFE_OFS_INPUT_CFG  = 8'h05;
	localparam logic [7:0] VAFE_OFS_GAIN_0     = 8'h06;
	localparam logic [7:0] VAFE_OFS_GAIN_1     = 8'h07;
	localparam logic [7:0] VAFE_OFS_GAIN_2     = 8'h08;
	localparam logic [7:0] VAFE_OFS_BLACK_CFG  = 8'h17;
	localparam logic [7:0] VAFE_OFS_POWER      = 8'h1B;
	localparam logic [7:0] VAFE_OFS_TUNING     = 8'h1C;
	localparam logic [7:0] VAFE_OFS_CLAMP      = 8'h23;
	localparam logic [7:0] VAFE_OFS_XTAL       = 8'h2B;
	localparam logic [7:0] VAFE_OFS_PHASE      = 8'h30;
	localparam logic [7:0] VAFE_OFS_PPL_LO     = 8'h31;
	localparam logic [7:0] VAFE_OFS_PPL_HI     = 8'h32;
	localparam logic [7:0] VAFE_OFS_DAC_R_LO   = 8'h33;
	localparam logic [7:0] VAFE_OFS_DAC_G_LO   = 8'h34;
	localparam logic [7:0] VAFE_OFS_DAC_B_LO   = 8'h35;
	localparam logic [7:0] VAFE_OFS_DAC_HI     = 8'h36;
	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0] VAFE_RST_POWER      = 8'h00;
	localparam logic [7:0] VAFE_RST_TUNING     = 8'h47;
	localparam logic [7:0] VAFE_RST_CLAMP      = 8'h08;
	localparam logic [7:0] VAFE_RST_XTAL       = 8'h14;
	localparam logic [7:0] VAFE_RST_GAIN       = 8'h55;
	localparam logic [7:0] VAFE_RST_OFFSET     = 8'h80;
	localparam logic [7:0] VAFE_RST_BLACK_CFG  = 8'h41;
	localparam logic [7:0] VAFE_RST_INPUT_CFG  = 8'h00;
	localparam logic [9:0] VAFE_RST_DAC        = 10'h200;
	localparam logic [7:0] VAFE_RST_PPL_LO     = 8'h20;
	localparam logic [7:0] VAFE_RST_PPL_HI     = 8'h03;
	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int VAFE_BIT_PLL_PD     = 3;
	localparam int VAFE_BIT_CLAMP_LO   = 4;
	localparam int VAFE_BIT_YUV        = 2;
	localparam int VAFE_BIT_LOOP_EN    = 0;
	localparam int VAFE_BIT_PIXW_LO    = 2;
	localparam int VAFE_BIT_BW_LO      = 4;
	// ------------------------------------------------------------
	// Black-level loop figures
	// ------------------------------------------------------------
	localparam int VAFE_BASE_PIX_LOG2  = 4;
	localparam int VAFE_BASE_TC_LOG2   = 5;
	localparam logic [7:0] VAFE_BLACK_MID = 8'h80;
	localparam logic [7:0] VAFE_BLACK_LOW = 8'h00;
	localparam int VAFE_PHASE_STEPS    = 64;
endpackage : vafe_pkg

/* File: design/vafe_ctrl.sv */
/*
 * Control logic of a three-channel video digitizer: power-down, clamp
 * impedance, sampling phase and pixel count, gain latching and the
 * automatic black-level loop driving three 10-bit offset DACs.
 * Assumes a plain register port, a line strobe (i_clamp) once per line,
 * and per-pixel black samples from the converters inside the
 * averaging window, all on i_clk.
 */
`timescale 1ns/1ns
module vafe_ctrl
	import vafe_pkg::*;
#(
	parameter int DAC_W = 10
) (
	input  wire logic             i_clk,
	input  wire logic             i_rst_n,
	input  wire logic [7:0]       i_addr,
	input  wire logic [7:0]       i_wdata,
	input  wire logic             i_wr,
	input  wire logic             i_rd,
	output logic      [7:0]       o_rdata,
	input  wire logic             i_clamp,
	input  wire logic             i_black_vld,
	input  wire logic [23:0]      i_black,
	output logic      [2:0]       o_adc_pd,
	output logic                  o_pll_pd,
	output logic      [2:0]       o_clamp_imp,
	output logic      [5:0]       o_phase,
	output logic      [11:0]      o_pix_per_line,
	output logic      [23:0]      o_gain,
	output logic      [3*DAC_W-1:0] o_dac,
	output logic                  o_yuv
);
	// ------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------
	logic [7:0] power_down;
	logic [7:0] tuning;
	logic [7:0] clamp_set;
	logic [7:0] xtal;
	logic [7:0] input_cfg;
	logic [7:0] black_cfg;
	logic [7:0] phase;
	logic [11:0] ppl;
	logic [7:0] gain_sw [3];
	logic [7:0] offset_sw [3];
	logic [DAC_W-1:0] dac_sw [3];
	logic [DAC_W-1:0] dac [3];
	logic loop_en;

	assign loop_en = black_cfg[VAFE_BIT_LOOP_EN];

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			power_down <= VAFE_RST_POWER;
			tuning     <= VAFE_RST_TUNING;
			clamp_set  <= VAFE_RST_CLAMP;
			xtal       <= VAFE_RST_XTAL;
			input_cfg  <= VAFE_RST_INPUT_CFG;
			black_cfg  <= VAFE_RST_BLACK_CFG;
			phase      <= 8'h00;
			ppl        <= {VAFE_RST_PPL_HI[3:0], VAFE_RST_PPL_LO};
		end else if (i_wr) begin
			unique case (i_addr)
				VAFE_OFS_POWER:     power_down <= {4'h0, i_wdata[3:0]};
				VAFE_OFS_TUNING:    tuning     <= i_wdata;
				VAFE_OFS_CLAMP:     clamp_set  <= {1'b0, i_wdata[6:0]};
				VAFE_OFS_XTAL:      xtal       <= i_wdata;
				VAFE_OFS_INPUT_CFG: input_cfg  <= i_wdata;
				VAFE_OFS_BLACK_CFG: black_cfg  <= i_wdata;
				VAFE_OFS_PHASE:     phase      <= {2'b00, i_wdata[5:0]};
				VAFE_OFS_PPL_LO:    ppl[7:0]   <= i_wdata;
				VAFE_OFS_PPL_HI:    ppl[11:8]  <= i_wdata[3:0];
				default: ;
			endcase
		end
	end

	// Per-channel gain and offset registers
	genvar ch;
	generate
		for (ch = 0; ch < 3; ch++) begin : g_ch
			localparam logic [7:0] GOFS = VAFE_OFS_GAIN_0 + 8'(ch);
			localparam logic [7:0] OOFS = (ch == 0) ? VAFE_OFS_OFFSET_R :
				(ch == 1) ? VAFE_OFS_OFFSET_G : VAFE_OFS_OFFSET_B;
			localparam logic [7:0] DOFS = VAFE_OFS_DAC_R_LO + 8'(ch);
			always_ff @(posedge i_clk) begin
				if (!i_rst_n) begin
					gain_sw[ch]   <= VAFE_RST_GAIN;
					offset_sw[ch] <= VAFE_RST_OFFSET;
					dac_sw[ch]    <= VAFE_RST_DAC;
				end else if (i_wr) begin
					if (i_addr == GOFS) begin
						gain_sw[ch] <= i_wdata;
					end
					if (i_addr == OOFS) begin
						offset_sw[ch] <= i_wdata;
					end
					if (i_addr == DOFS) begin
						dac_sw[ch][7:0] <= i_wdata;
					end
					if (i_addr == VAFE_OFS_DAC_HI) begin
						dac_sw[ch][DAC_W-1:8] <= i_wdata[2*ch +: 2];
					end
				end
			end

			// Gain reaches the amplifier only on the line's clamp
			always_ff @(posedge i_clk) begin
				if (!i_rst_n) begin
					o_gain[8*ch +: 8] <= VAFE_RST_GAIN;
				end else if (i_clamp) begin
					o_gain[8*ch +: 8] <= gain_sw[ch];
				end
			end

			// Black-level loop; gain plays no part here
			logic [15:0] acc;
			logic [7:0]  cnt;
			logic [15:0] avg;
			logic [9:0]  target;
			logic [9:0]  meas;
			logic [12:0] lines;
			logic        line_done;
			logic [7:0]  npix;
			logic [12:0] tc;
			assign npix = 8'(1 << (VAFE_BASE_PIX_LOG2 + black_cfg[3:2]));
			assign tc   = 13'(1 << (VAFE_BASE_TC_LOG2 + black_cfg[6:4]));
			assign avg  = acc >> (VAFE_BASE_PIX_LOG2 + black_cfg[3:2]);
			assign meas = {avg[7:0], 2'b00};
			// Target in quarter LSB: black code plus manual shift, 0x80 neutral
			// Shift in whole LSBs, held to 64 codes; sum floored at zero
			logic [7:0]         black_code;
			logic signed [7:0]  ofs_diff;
			logic signed [7:0]  ofs_lim;
			logic signed [10:0] tgt_sum;
			assign black_code = ((ch != 1) && input_cfg[VAFE_BIT_YUV]) ?
				VAFE_BLACK_MID : VAFE_BLACK_LOW;
			assign ofs_diff   = $signed(offset_sw[ch] ^ 8'h80);
			assign ofs_lim    = (ofs_diff > 8'sd64) ? 8'sd64 :
				(ofs_diff < -8'sd64) ? -8'sd64 : ofs_diff;
			assign tgt_sum    = $signed({1'b0, black_code, 2'b00}) +
				$signed({ofs_lim[7], ofs_lim, 2'b00});
			assign target     = tgt_sum[10] ? 10'h000 : tgt_sum[9:0];
			always_ff @(posedge i_clk) begin
				if (!i_rst_n) begin
					acc   <= 16'h0000;
					cnt   <= 8'h00;
					lines <= 13'h0000;
					dac[ch] <= VAFE_RST_DAC;
				end else if (!loop_en) begin
					acc     <= 16'h0000;
					cnt     <= 8'h00;
					dac[ch] <= dac_sw[ch];
				end else if (i_clamp) begin
					acc <= 16'h0000;
					cnt <= 8'h00;
					if (cnt >= npix) begin
						lines <= (lines + 13'h0001 >= tc) ? 13'h0000 : lines + 13'h0001;
						// One quarter-LSB step per time constant
						if (lines + 13'h0001 >= tc) begin
							if (meas > target && dac[ch] != '0) begin
								dac[ch] <= dac[ch] - DAC_W'(1);
							end else if (meas < target && dac[ch] != '1) begin
								dac[ch] <= dac[ch] + DAC_W'(1);
							end
						end
					end
				end else if (i_black_vld && cnt < npix) begin
					acc <= acc + 16'(i_black[8*ch +: 8]);
					cnt <= cnt + 8'h01;
				end
			end

			always_ff @(posedge i_clk) begin
				if (!i_rst_n) begin
					o_dac[DAC_W*ch +: DAC_W] <= VAFE_RST_DAC;
				end else begin
					o_dac[DAC_W*ch +: DAC_W] <= dac[ch];
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// Control outputs
	// ------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_adc_pd       <= 3'h0;
			o_pll_pd       <= 1'b0;
			o_clamp_imp    <= 3'h0;
			o_phase        <= 6'h00;
			o_pix_per_line <= 12'h000;
			o_yuv          <= 1'b0;
		end else begin
			o_adc_pd       <= power_down[2:0];
			o_pll_pd       <= power_down[VAFE_BIT_PLL_PD];
			o_clamp_imp    <= clamp_set[VAFE_BIT_CLAMP_LO +: 3];
			// Phase and count change only at line start, so no step mid-line
			if (i_clamp) begin
				o_phase        <= phase[5:0];
				o_pix_per_line <= ppl;
			end
			o_yuv          <= input_cfg[VAFE_BIT_YUV];
		end
	end

	// ------------------------------------------------------------
	// Read port
	// ------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_rdata <= 8'h00;
		end else if (i_rd) begin
			unique case (i_addr)
				VAFE_OFS_POWER:     o_rdata <= power_down;
				VAFE_OFS_TUNING:    o_rdata <= tuning;
				VAFE_OFS_CLAMP:     o_rdata <= clamp_set;
				VAFE_OFS_XTAL:      o_rdata <= xtal;
				VAFE_OFS_INPUT_CFG: o_rdata <= input_cfg;
				VAFE_OFS_BLACK_CFG: o_rdata <= black_cfg;
				VAFE_OFS_PHASE:     o_rdata <= phase;
				VAFE_OFS_PPL_LO:    o_rdata <= ppl[7:0];
				VAFE_OFS_PPL_HI:    o_rdata <= {4'h0, ppl[11:8]};
				VAFE_OFS_GAIN_0:    o_rdata <= gain_sw[0];
				VAFE_OFS_GAIN_1:    o_rdata <= gain_sw[1];
				VAFE_OFS_GAIN_2:    o_rdata <= gain_sw[2];
				VAFE_OFS_OFFSET_R:  o_rdata <= offset_sw[0];
				VAFE_OFS_OFFSET_G:  o_rdata <= offset_sw[1];
				VAFE_OFS_OFFSET_B:  o_rdata <= offset_sw[2];
				// Reads show live DAC codes, loop state included
				VAFE_OFS_DAC_R_LO:  o_rdata <= dac[0][7:0];
				VAFE_OFS_DAC_G_LO:  o_rdata <= dac[1][7:0];
				VAFE_OFS_DAC_B_LO:  o_rdata <= dac[2][7:0];
				VAFE_OFS_DAC_HI:    o_rdata <= {2'b00, dac[2][9:8], dac[1][9:8], dac[0][9:8]};
				default:            o_rdata <= 8'h00;
			endcase
		end else begin
			o_rdata <= 8'h00;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_pd_follow: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_wr && i_addr == VAFE_OFS_POWER |=> ##1 o_adc_pd == $past(i_wdata[2:0], 2))
		else $error("power-down bits not applied");
	a_pll_pd: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_wr && i_addr == VAFE_OFS_POWER |=> ##1 o_pll_pd == $past(i_wdata[3], 2))
		else $error("pll power-down wrong");
	a_clamp_imp: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_wr && i_addr == VAFE_OFS_CLAMP |=> ##1 o_clamp_imp == $past(i_wdata[6:4], 2))
		else $error("clamp impedance wrong");
	a_gain_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		!i_clamp |=> $stable(o_gain))
		else $error("gain changed without clamp");
	a_gain_load: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_clamp |=> o_gain == {$past(gain_sw[2]), $past(gain_sw[1]), $past(gain_sw[0])})
		else $error("gain not loaded at clamp");
	a_phase_line: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		!i_clamp |=> $stable(o_phase) && $stable(o_pix_per_line))
		else $error("phase moved within a line");
	a_dac_manual: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		!loop_en ##1 !loop_en |=> o_dac[9:0] == $past(dac_sw[0], 2))
		else $error("manual dac not followed");
	a_dac_step: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		loop_en && $past(loop_en) |-> dac[0] - $past(dac[0]) inside {10'h000, 10'h001, 10'h3FF})
		else $error("dac step too large");
endmodule // vafe_ctrl

/* File: testbench/vafe_ctrl_test.sv */
/*
 * Self-checking bench for vafe_ctrl: register map, power and clamp
 * controls, gain latching, manual and automatic offset DAC control.
 * Assumes vafe_pkg is compiled first and one 10 MHz clock drives all.
 */
`timescale 1ns/1ns
module vafe_ctrl_test;
	import vafe_pkg::*;
	logic        i_clk, i_rst_n, i_wr, i_rd, i_clamp, i_black_vld, rd_seen;
	logic [7:0]  i_addr, i_wdata, o_rdata, lf;
	logic [23:0] i_black, o_gain;
	logic [2:0]  o_adc_pd, o_clamp_imp;
	logic        o_pll_pd, o_yuv;
	logic [5:0]  o_phase;
	logic [11:0] o_pix_per_line;
	logic [29:0] o_dac, d0;
	logic [7:0]  g [3];
	logic [7:0]  exp_q [$];
	logic [7:0]  ra [11] = '{8'h1B, 8'h1C, 8'h23, 8'h2B, 8'h06, 8'h07, 8'h08,
		8'h03, 8'h04, 8'h09, 8'hFF};
	logic [7:0]  rv [11] = '{8'h00, 8'h47, 8'h08, 8'h14, 8'h55, 8'h55, 8'h55,
		8'h80, 8'h80, 8'h80, 8'h00};
	logic [7:0]  oa [3] = '{8'h03, 8'h04, 8'h09};
	int          err_count, samples_checked, cyc;

	vafe_ctrl #(.DAC_W(10)) vafe_ctrl_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.o_rdata(o_rdata), .i_clamp(i_clamp), .i_black_vld(i_black_vld),
		.i_black(i_black), .o_adc_pd(o_adc_pd), .o_pll_pd(o_pll_pd),
		.o_clamp_imp(o_clamp_imp), .o_phase(o_phase),
		.o_pix_per_line(o_pix_per_line), .o_gain(o_gain), .o_dac(o_dac),
		.o_yuv(o_yuv));

	// ------------------------------------------------------------
	// Clock, timeout, read monitor
	// ------------------------------------------------------------
	initial begin
		i_clk = 0;
		forever #50 i_clk = ~i_clk;
	end
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (cyc == 10000) begin
			err_count++;
			results;
		end
	end
	always @(posedge i_clk) rd_seen <= i_rd;
	// Read data stands only in the cycle after the strobe
	always @(negedge i_clk) if (rd_seen) chk(o_rdata, exp_q.pop_front());

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	function automatic logic [7:0] nxt(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	function automatic logic [9:0] dd(input logic [9:0] a, input logic [9:0] b);
		return (a > b) ? a - b : b - a;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] e);
		samples_checked++;
		if (got !== e) begin
			err_count++;
			$display("FAIL %0t got %h expected %h", $time, got, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_wr <= 1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 0;
		i_wdata <= ~d;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge i_clk);
		i_rd <= 1;
		i_addr <= a;
		exp_q.push_back(e);
		@(posedge i_clk);
		i_rd <= 0;
	endtask
	task automatic wait2;
		repeat (2) @(negedge i_clk);
	endtask
	// Sixteen black samples, then the line's clamp pulse
	task automatic line(input logic [23:0] b);
		@(posedge i_clk);
		i_black_vld <= 1;
		i_black <= b;
		repeat (16) @(posedge i_clk);
		i_black_vld <= 0;
		i_black <= ~b;
		i_clamp <= 1;
		@(posedge i_clk);
		i_clamp <= 0;
	endtask
	task automatic results;
		if (err_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		i_rst_n = 0; i_wr = 0; i_rd = 0; i_clamp = 0; i_black_vld = 0;
		i_addr = 0; i_wdata = 0; i_black = 0; lf = 8'h34;
		err_count = 0; samples_checked = 0; cyc = 0;
		repeat (6) @(posedge i_clk);
		i_rst_n <= 1;
		wait2;
		chk({o_pll_pd, o_adc_pd, o_clamp_imp}, 0);
		chk(o_dac, {3{10'h200}});
		for (int i = 0; i < 11; i++) rd(ra[i], rv[i]);
		for (int b = 0; b < 4; b++) begin
			wr(VAFE_OFS_POWER, 8'hF0 | 8'(1 << b));
			wait2;
			chk({o_pll_pd, o_adc_pd}, 1 << b);
			rd(VAFE_OFS_POWER, 8'(1 << b));
		end
		wr(VAFE_OFS_TUNING, 8'h49);
		rd(VAFE_OFS_TUNING, 8'h49);
		for (int c = 0; c < 8; c++) begin
			wr(VAFE_OFS_CLAMP, {1'b1, 3'(c), 4'h8});
			wait2;
			chk(o_clamp_imp, c);
			rd(VAFE_OFS_CLAMP, {1'b0, 3'(c), 4'h8});
		end
		// Gain, phase and pixel count wait for the clamp pulse
		for (int i = 0; i < 3; i++) begin
			g[i] = lf;
			lf = nxt(lf);
			wr(VAFE_OFS_GAIN_0 + 8'(i), g[i]);
			rd(VAFE_OFS_GAIN_0 + 8'(i), g[i]);
		end
		d0 = o_dac;
		wr(VAFE_OFS_PHASE, 8'h3F);
		wr(VAFE_OFS_PPL_LO, 8'h34);
		wr(VAFE_OFS_PPL_HI, 8'h02);
		wait2;
		chk(o_gain, 24'h555555);
		@(posedge i_clk);
		i_clamp <= 1;
		@(posedge i_clk);
		i_clamp <= 0;
		wait2;
		chk(o_gain, {g[2], g[1], g[0]});
		chk(o_phase, 63);
		chk(o_pix_per_line, 12'h234);
		chk(o_dac, d0);
		for (int i = 0; i < 3; i++) begin
			g[i] = lf;
			lf = nxt(lf);
			wr(oa[i], g[i]);
		end
		for (int i = 0; i < 3; i++) begin
			rd(oa[i], g[i]);
			wr(oa[i], 8'h80);
		end
		// Manual DAC codes with the loop off
		wr(VAFE_OFS_BLACK_CFG, 8'h40);
		for (int i = 0; i < 3; i++) begin
			g[i] = lf;
			lf = nxt(lf);
			wr(VAFE_OFS_DAC_R_LO + 8'(i), g[i]);
		end
		wr(VAFE_OFS_DAC_HI, 8'h1B);
		wait2;
		// Register, loop stage, then output flop: one cycle more
		@(negedge i_clk);
		chk(o_dac, {2'h1, g[2], 2'h2, g[1], 2'h3, g[0]});
		rd(VAFE_OFS_DAC_G_LO, g[1]);
		d0 = o_dac;
		// Loop on, shortest time constant: one step after 32 lines
		wr(VAFE_OFS_BLACK_CFG, 8'h01);
		repeat (31) line(24'h101010);
		wait2;
		chk(o_dac, d0);
		line(24'h101010);
		wait2;
		for (int i = 0; i < 3; i++) chk(dd(o_dac[i*10+:10], d0[i*10+:10]), 1);
		wr(VAFE_OFS_INPUT_CFG, 8'h04);
		wait2;
		chk(o_yuv, 1);
		d0 = o_dac;
		repeat (32) line(24'h800080);
		wait2;
		chk(o_dac, d0);
		// Red shifted up four codes, blue down past the limit
		wr(oa[0], 8'h84);
		wr(oa[2], 8'h00);
		repeat (32) line(24'h300083);
		wait2;
		chk(o_dac - d0, {10'h001, 10'h000, 10'h001});
		// Wider averaging window: 16-sample lines no longer count
		d0 = o_dac;
		wr(VAFE_OFS_BLACK_CFG, 8'h05);
		repeat (32) line(24'h101010);
		wait2;
		chk(o_dac, d0);
		wr(VAFE_OFS_BLACK_CFG, 8'h00);
		repeat (32) line(24'h101010);
		wait2;
		chk(o_dac, {2'h1, g[2], 2'h2, g[1], 2'h3, g[0]});
		results;
	end
endmodule // vafe_ctrl_test
